// ### verilog/ahp_host_port.sv
/*
  Parallel processor-side port of a four-input converter: strobe decode,
  configuration words zero and one, soft reset, sync clear, output format,
  test voltage select and offset calibration of result words.
  Assumes pins are asynchronous to clock; results arrive on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "ahp_cfg.svh"
module ahp_host_port
  import ahp_pkg::*;
#(
  parameter int RES_W = `AHP_RES_W
) (
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic                    chip_select_low_active_n,
  input  wire logic                    chip_select_high_active,
  input  wire logic                    rd_n,
  input  wire logic                    wr_n,
  input  wire logic [`AHP_DATA_W-1:0]  data_in,
  output logic      [`AHP_DATA_W-1:0]  data_out,
  output logic                         data_oe,
  input  wire logic [RES_W-1:0]        conv_raw,
  input  wire logic                    conv_valid,
  output logic                         conv_zero_input,
  output logic [1:0]                   check_voltage_sel,
  output logic                         sync_gen_clear,
  output logic                         device_reset,
  output logic                         output_code_format,
  output logic                         cal_busy,
  output logic [`AHP_RES_W-1:0]        word0_out
);
  // Only the documented result width is served
  if (RES_W != `AHP_RES_W) begin : g_res_w_check
    $error("RES_W must match the result width");
  end

  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [`AHP_DATA_W-1:0] din_s1_reg;
  logic [`AHP_DATA_W-1:0] din_s2_reg;
  logic rd_int;
  logic wr_int;
  logic wr_int_d_reg;
  logic [`AHP_DATA_W-1:0] wdata_reg;
  logic [`AHP_RES_W-1:0] word0_reg;
  logic [`AHP_RES_W-1:0] word1_reg;
  logic [`AHP_RES_W-1:0] offset_reg;
  logic [`AHP_RES_W-1:0] result_reg;
  logic [3:0] cal_cnt_reg;
  ahp_cal_t cal_state_reg;
  logic wr_take;
  logic [1:0] wsel;

  // Two-stage synchronisers for all pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      // Idle levels, so that no false strobe follows reset
      pin_s1_reg <= `AHP_PIN_IDLE;
      pin_s2_reg <= `AHP_PIN_IDLE;
      din_s1_reg <= 12'h000;
      din_s2_reg <= 12'h000;
    end else begin
      pin_s1_reg <= {chip_select_low_active_n, chip_select_high_active,
                     rd_n, wr_n};
      pin_s2_reg <= pin_s1_reg;
      din_s1_reg <= data_in;
      din_s2_reg <= din_s1_reg;
    end
  end

  ahp_strobe_gen u_strobe (
    .clock                    (clock),
    .rst_n                    (rst_n),
    .chip_select_low_active_n (pin_s2_reg[3]),
    .chip_select_high_active  (pin_s2_reg[2]),
    .rd_n                     (pin_s2_reg[1]),
    .wr_n                     (pin_s2_reg[0]),
    .combined_mode            (word1_reg[`AHP_W1_STRB_BIT]),
    .rd_int                   (rd_int),
    .wr_int                   (wr_int)
  );

  // Word is latched at the falling edge of the write strobe, when data is
  // guaranteed settled; this costs one cycle after the strobe ends.
  always_comb begin
    wr_take = wr_int_d_reg && !wr_int;
    wsel = wdata_reg[`AHP_SEL_HI:`AHP_SEL_LO];
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_int_d_reg <= 1'b0;
    end else begin
      wr_int_d_reg <= wr_int;
    end
  end

  // Held data sampled while the strobe is up
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wdata_reg <= 12'h000;
    end else if (wr_int) begin
      wdata_reg <= din_s2_reg;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      word0_reg <= `AHP_W0_RESET;
      word1_reg <= `AHP_W1_RESET;
    end else if (wr_take) begin
      if (wsel == `AHP_SEL_WORD1) begin
        if (wdata_reg[`AHP_W1_RESET_BIT]) begin
          word0_reg <= `AHP_W0_RESET;
          word1_reg <= `AHP_W1_RESET | 10'h001;
        end else begin
          word1_reg <= wdata_reg[`AHP_RES_W-1:0];
        end
      end else if (wsel == `AHP_SEL_WORD0
                   && !word1_reg[`AHP_W1_RESET_BIT]) begin
        word0_reg <= wdata_reg[`AHP_RES_W-1:0];
      end
    end else if (word1_reg[`AHP_W1_SYNC_BIT]) begin
      word1_reg[`AHP_W1_SYNC_BIT] <= 1'b0;
    end else if (cal_state_reg == AHP_CAL_STORE) begin
      word1_reg[`AHP_W1_OFS_BIT] <= 1'b0;
    end
  end

  // Offset calibration: zero inputs, wait, store next conversion
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cal_state_reg <= AHP_CAL_IDLE;
      cal_cnt_reg <= 4'h0;
      offset_reg <= 10'h000;
    end else if (word1_reg[`AHP_W1_RESET_BIT]) begin
      cal_state_reg <= AHP_CAL_IDLE;
      offset_reg <= 10'h000;
    end else begin
      unique case (cal_state_reg)
        AHP_CAL_IDLE: begin
          cal_cnt_reg <= 4'h0;
          if (word1_reg[`AHP_W1_OFS_BIT]) begin
            cal_state_reg <= AHP_CAL_ZERO;
          end
        end
        AHP_CAL_ZERO: begin
          if (cal_cnt_reg != `AHP_CAL_CYCLES) begin
            cal_cnt_reg <= cal_cnt_reg + 4'h1;
          end else if (conv_valid) begin
            offset_reg <= conv_raw;
            cal_state_reg <= AHP_CAL_STORE;
          end
        end
        AHP_CAL_STORE: begin
          cal_state_reg <= AHP_CAL_IDLE;
        end
      endcase
    end
  end

  // Result: offset removed, then format; sign flip gives straight binary
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= 10'h000;
    end else if (conv_valid && cal_state_reg == AHP_CAL_IDLE) begin
      result_reg <= (conv_raw - offset_reg) ^
                    {word1_reg[`AHP_W1_FMT_BIT], 9'h000};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= 12'h000;
      data_oe <= 1'b0;
    end else begin
      data_oe <= rd_int;
      data_out <= {2'h0, result_reg};
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      conv_zero_input <= 1'b0;
      check_voltage_sel <= 2'h0;
      sync_gen_clear <= 1'b0;
      device_reset <= 1'b0;
      output_code_format <= 1'b0;
      cal_busy <= 1'b0;
      word0_out <= `AHP_W0_RESET;
    end else begin
      conv_zero_input <= cal_state_reg == AHP_CAL_ZERO;
      check_voltage_sel <=
        word0_reg[`AHP_W0_TEST_HI:`AHP_W0_TEST_LO];
      sync_gen_clear <= word1_reg[`AHP_W1_SYNC_BIT];
      device_reset <= word1_reg[`AHP_W1_RESET_BIT];
      output_code_format <= word1_reg[`AHP_W1_FMT_BIT];
      cal_busy <= cal_state_reg != AHP_CAL_IDLE;
      word0_out <= word0_reg;
    end
  end
endmodule
`default_nettype wire

// ### verilog/ahp_cfg.svh
/*
  Constants of the converter host port: register word layout, reset values,
  field positions and timing counts.
  Assumes inclusion by bare name; holds definitions only.
*/
`ifndef AHP_CFG_SVH
`define AHP_CFG_SVH

`define AHP_DATA_W        12
`define AHP_RES_W         10
// Word select: bits 11:10 of a written word pick the configuration word
`define AHP_SEL_HI        11
`define AHP_SEL_LO        10
`define AHP_SEL_WORD0     2'h0
`define AHP_SEL_WORD1     2'h1
// Idle pin levels {select low, select high, read, write}: nothing selected
`define AHP_PIN_IDLE      4'hb
// Word zero
`define AHP_W0_TEST_HI    9
`define AHP_W0_TEST_LO    8
`define AHP_W0_RESET      10'h020
// Word one
`define AHP_W1_RESET_BIT  0
`define AHP_W1_SYNC_BIT   1
`define AHP_W1_STRB_BIT   6
`define AHP_W1_FMT_BIT    7
`define AHP_W1_OFS_BIT    8
`define AHP_W1_RESET      10'h030
// Offset calibration settles this many cycles after start
`define AHP_CAL_CYCLES    4'h4
// Sign bit of a result word
`define AHP_RES_MSB       9

`endif

// ### verilog/ahp_pkg.sv
/*
  Types of the converter host port.
  Assumes ahp_cfg.svh is on the include path.
*/
package ahp_pkg;
  typedef enum logic [1:0] {
    AHP_TEST_NORMAL,
    AHP_TEST_UPPER,
    AHP_TEST_MID,
    AHP_TEST_LOWER
  } ahp_test_t;

  typedef enum logic [1:0] {
    AHP_CAL_IDLE,
    AHP_CAL_ZERO,
    AHP_CAL_STORE
  } ahp_cal_t;
endpackage

// ### verilog/ahp_strobe_gen.sv
/*
  Internal read and write strobe generation from the chip selects and the
  read/write pins, in separate or combined direction mode.
  Assumes the pins are already synchronised to clock.
*/
`timescale 1ns/1ps
`default_nettype none
module ahp_strobe_gen (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic chip_select_low_active_n,
  input  wire logic chip_select_high_active,
  input  wire logic rd_n,
  input  wire logic wr_n,
  input  wire logic combined_mode,
  output var  logic rd_int,
  output var  logic wr_int
);
  logic sel;
  logic rd_req;
  logic wr_req;

  always_comb begin
    sel = !chip_select_low_active_n && chip_select_high_active;
    if (combined_mode) begin
      // Write pin is the direction line; read pin is ignored
      rd_req = sel && wr_n;
      wr_req = sel && !wr_n;
    end else begin
      rd_req = sel && !rd_n && wr_n;
      wr_req = sel && !wr_n && rd_n;
    end
  end

  // Strobes fall at the next clock edge after any term goes inactive
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_int <= 1'b0;
      wr_int <= 1'b0;
    end else begin
      rd_int <= rd_req;
      wr_int <= wr_req;
    end
  end
endmodule
`default_nettype wire

// ### test/ahp_host_port_properties.sv
/* Checker of the host port outputs.
   Bound to ahp_host_port by tb; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
`include "ahp_cfg.svh"
module ahp_host_port_properties #(
  parameter int RES_W = `AHP_RES_W
) (
  input wire logic             clock,
  input wire logic             rst_n,
  input wire logic             chip_select_low_active_n,
  input wire logic             chip_select_high_active,
  input wire logic             rd_n,
  input wire logic             wr_n,
  input wire logic [11:0]      data_out,
  input wire logic             data_oe,
  input wire logic             conv_zero_input,
  input wire logic [1:0]       check_voltage_sel,
  input wire logic             sync_gen_clear,
  input wire logic             device_reset,
  input wire logic             output_code_format,
  input wire logic             cal_busy,
  input wire logic [9:0]       word0_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic sel = !chip_select_low_active_n && chip_select_high_active;
  sequence rd_req;
    sel && !rd_n && wr_n && !device_reset;
  endsequence
  sequence wr_req;
    sel && !wr_n;
  endsequence
  a_read_drives: assert property (rd_req [*6] |-> data_oe)
    else $error("bus not driven during read");
  a_bus_release: assert property (!sel [*6] |-> !data_oe)
    else $error("bus driven without select");
  a_no_rd_on_wr: assert property (wr_req [*6] |-> !data_oe)
    else $error("bus driven during write");
  a_test_follows: assert property ($changed(word0_out) |->
    ##[0:2] check_voltage_sel == word0_out[9:8])
    else $error("test select differs from word zero");
  a_reset_words: assert property ($rose(device_reset) |->
    ##[0:2] (word0_out == `AHP_W0_RESET && !output_code_format))
    else $error("words not restored by soft reset");
  a_sync_pulse: assert property (sync_gen_clear |=> !sync_gen_clear)
    else $error("sync clear longer than one cycle");
  a_cal_zeroes: assert property ($rose(cal_busy) |-> ##[0:2] conv_zero_input)
    else $error("inputs not zeroed for calibration");
  a_cal_ends: assert property ($rose(cal_busy) |-> ##[1:60] !cal_busy)
    else $error("calibration does not finish");
  a_oe_word: assert property (data_oe |-> data_out[11:10] == 2'b00)
    else $error("result word upper bits set");
endmodule
`default_nettype wire

// ### test/ahp_host_model.sv
/* Host bus model driving selects, strobes and the write word.
   Assumes a free-running clock; tb calls its tasks. */
`timescale 1ns/1ps
`default_nettype none
module ahp_host_model (
  input  wire logic        clock,
  output var  logic        chip_select_low_active_n,
  output var  logic        chip_select_high_active,
  output var  logic        rd_n,
  output var  logic        wr_n,
  output var  logic [11:0] data_in
);
  initial begin
    chip_select_low_active_n = 1'b1;
    chip_select_high_active = 1'b0;
    rd_n = 1'b1;
    wr_n = 1'b1;
    data_in = 12'h000;
  end
  task automatic sel(logic on);
    chip_select_low_active_n <= !on;
    chip_select_high_active <= on;
  endtask
  // Select drops first so it ends the cycle; data outlives the strobe
  task automatic xfer(logic rd_on, logic wr_on, logic [11:0] w);
    @(posedge clock);
    data_in <= w;
    rd_n <= !rd_on;
    wr_n <= !wr_on;
    sel(1'b1);
    repeat (8) @(posedge clock);
    sel(1'b0);
    repeat (4) @(posedge clock);
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    data_in <= ~w;
    repeat (6) @(posedge clock);
  endtask
  task automatic wr(logic [11:0] w);
    xfer(1'b0, 1'b1, w);
  endtask
  task automatic rd(logic use_rd);
    xfer(use_rd, 1'b0, 12'h000);
  endtask
endmodule
`default_nettype wire

// ### test/tb.sv
/* Self-checking bench of the converter host port.
   Assumes the host model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "ahp_cfg.svh"
module tb;
  import ahp_pkg::*;
  logic        clock, rst_n, chip_select_low_active_n, chip_select_high_active;
  logic        rd_n, wr_n, data_oe, conv_valid, conv_zero_input, oe_q, fmt;
  logic        sync_gen_clear, device_reset, output_code_format, cal_busy;
  logic [11:0] data_in, data_out;
  logic [9:0]  conv_raw, word0_out, raw, ofs, w0;
  logic [1:0]  check_voltage_sel;
  logic [11:0] exp_q[$];
  int          miscompares, cmp_count, oe_cnt, sync_cnt, n;
  ahp_host_port i_dut (.clock, .rst_n, .chip_select_low_active_n,
    .chip_select_high_active, .rd_n, .wr_n, .data_in, .data_out, .data_oe,
    .conv_raw, .conv_valid, .conv_zero_input, .check_voltage_sel,
    .sync_gen_clear, .device_reset, .output_code_format, .cal_busy,
    .word0_out);
  ahp_host_model i_host (.clock, .chip_select_low_active_n,
    .chip_select_high_active, .rd_n, .wr_n, .data_in);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    conv_valid = 1'b0;
    conv_raw = 10'h000;
    forever begin
      repeat (4) @(posedge clock);
      conv_raw <= raw;
      conv_valid <= 1'b1;
      @(posedge clock);
      conv_valid <= 1'b0;
    end
  end
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Oldest expected word is matched at each rise of the bus enable
  always @(negedge clock) begin
    oe_q <= data_oe;
    if (sync_gen_clear === 1'b1) sync_cnt++;
    if (data_oe === 1'b1 && oe_q !== 1'b1) begin
      oe_cnt++;
      chk("read word", exp_q.size() ? exp_q.pop_front() : 12'hfff, data_out);
    end
  end
  task automatic rd(logic [9:0] v, logic comb);
    logic [9:0] e;
    raw = v;
    repeat (10) @(posedge clock);
    e = v - ofs;
    if (fmt) e[9] = ~e[9];
    exp_q.push_back({2'b00, e});
    i_host.rd(!comb);
  endtask
  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    results;
  end
  initial begin
    {rst_n, raw, ofs, fmt} = '0;
    void'($urandom(32'h585a));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk("word zero", {2'h0, `AHP_W0_RESET}, {2'h0, word0_out});
    for (int t = 0; t < 4; t++) begin
      w0 = {t[1:0], 8'($urandom)};
      i_host.wr({2'b00, w0});
      chk("test select", {10'h0, w0[9:8]}, {10'h0, check_voltage_sel});
    end
    rd(10'($urandom), 1'b0);
    n = oe_cnt;
    i_host.rd(1'b0);
    chk("read count", 12'(n), 12'(oe_cnt));
    // Read and write both low in separate mode: neither strobe may rise
    i_host.xfer(1'b1, 1'b1, 12'h000);
    chk("read count", 12'(n), 12'(oe_cnt));
    chk("word zero", {2'h0, w0}, {2'h0, word0_out});
    n = sync_cnt;
    i_host.wr(12'h4B2);
    fmt = 1'b1;
    chk("sync pulses", 12'(n + 1), 12'(sync_cnt));
    chk("format", 12'h001, {11'h0, output_code_format});
    rd(10'($urandom), 1'b0);
    raw = 10'($urandom);
    repeat (10) @(posedge clock);
    i_host.wr(12'h5B0);
    for (int i = 0; i < 100 && cal_busy !== 1'b0; i++) @(posedge clock);
    ofs = raw;
    rd(10'($urandom), 1'b0);
    i_host.wr(12'h4F0);
    rd(10'($urandom), 1'b1);
    i_host.wr(12'h4F1);
    fmt = 1'b0;
    chk("soft reset", 12'h001, {11'h0, device_reset});
    i_host.wr(12'h155);
    chk("word zero", {2'h0, `AHP_W0_RESET}, {2'h0, word0_out});
    i_host.wr(12'h430);
    chk("soft reset", 12'h000, {11'h0, device_reset});
    i_host.wr({2'b00, w0});
    chk("word zero", {2'h0, w0}, {2'h0, word0_out});
    // Hardware reset in mid-run restores word zero and plain results
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    chk("word zero", {2'h0, `AHP_W0_RESET}, {2'h0, word0_out});
    {ofs, fmt} = '0;
    rd(10'($urandom), 1'b0);
    results;
  end
endmodule
bind ahp_host_port ahp_host_port_properties #(.RES_W(RES_W)) i_chk (
  .clock, .rst_n, .chip_select_low_active_n, .chip_select_high_active,
  .rd_n, .wr_n, .data_out, .data_oe, .conv_zero_input, .check_voltage_sel,
  .sync_gen_clear, .device_reset, .output_code_format, .cal_busy,
  .word0_out);
`default_nettype wire
